/* File: design/pbc_pkg.sv */
// package: register map, field positions and reset values of the pin port block
package pbc_pkg;
   // register byte addresses on the AXI4-Lite bus
   localparam logic [7:0] PBC_OFF_PIN_LEVEL = 8'h00;
   localparam logic [7:0] PBC_OFF_LATCH = 8'h04;
   localparam logic [7:0] PBC_OFF_DIRECTION = 8'h08;
   localparam logic [7:0] PBC_OFF_PULLUP = 8'h0C;
   localparam logic [7:0] PBC_OFF_CHG_EN = 8'h10;
   localparam logic [7:0] PBC_OFF_ANALOG = 8'h14;
   localparam logic [7:0] PBC_OFF_IRQ_CTRL = 8'h18;
   localparam logic [7:0] PBC_OFF_IRQ_CTRL2 = 8'h1C;
   localparam logic [7:0] PBC_OFF_SERIAL_CFG = 8'h20;
   // implemented pins sit at bits 7..4 of each 8-bit port register
   localparam int PBC_PIN_LO = 4;
   localparam int PBC_NPIN = 4;
   // irq_control fields
   localparam int PBC_BIT_CHG_FLAG = 0;
   localparam int PBC_BIT_CHG_GEN = 3;
   // irq_control_second fields
   localparam int PBC_BIT_CHG_PRIO = 0;
   localparam int PBC_BIT_PU_GDIS = 7;
   // analog_select_high fields: channel 10 on bit 2, channel 11 on bit 3
   localparam int PBC_BIT_ANALOG_CHANNEL_10 = 2;
   localparam int PBC_BIT_ANALOG_CHANNEL_11 = 3;
   // serial_cfg fields
   localparam int PBC_BIT_SPI_EN = 0;
   localparam int PBC_BIT_I2C_EN = 1;
   localparam int PBC_BIT_US_EN = 2;
   localparam int PBC_BIT_US_SYNC = 3;
   localparam int PBC_BIT_US_MASTER = 4;
   // reset values
   localparam logic [3:0] PBC_RST_DIRECTION = 4'hF;
   localparam logic [3:0] PBC_RST_PULLUP = 4'hF;
   localparam logic [3:0] PBC_RST_CHG_EN = 4'h0;
   localparam logic [3:0] PBC_RST_LATCH = 4'h0;
   localparam logic [3:0] PBC_RST_ANALOG = 4'hF;
   localparam logic [7:0] PBC_RST_IRQ_CTRL2 = 8'h81;
   localparam logic [1:0] PBC_RESP_OKAY = 2'h0;
   localparam logic [1:0] PBC_RESP_SLVERR = 2'h2;
endpackage

/* File: design/pbc_sync.sv */
// two-flop synchroniser bank for pin inputs
`timescale 1ns/1ns
`default_nettype none
module pbc_sync #(
   parameter int W = 4
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   // ----------------------------------------
   // synchroniser chain
   // ----------------------------------------
   // first stage feeds only the second
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule // pbc_sync
`default_nettype wire

/* File: design/pbc_axil.sv */
// AXI4-Lite slave front end: turns bus transfers into single-cycle strobes
`timescale 1ns/1ns
`default_nettype none
module pbc_axil (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   output logic wr_stb,
   output logic [7:0] wr_addr,
   output logic [7:0] wr_data,
   input wire logic wr_err,
   output logic rd_stb,
   output logic [7:0] rd_addr,
   input wire logic [7:0] rd_data,
   input wire logic rd_err
);
   import pbc_pkg::*;
   logic aw_held;
   logic w_held;
   logic [7:0] aw_q;
   logic [7:0] w_q;
   logic wr_go;
   // accept each write channel once, while no response is pending
   assign s_awready = !aw_held && !s_bvalid;
   assign s_wready = !w_held && !s_bvalid;
   assign s_arready = !s_rvalid;
   assign wr_go = aw_held && w_held && !s_bvalid;
   assign wr_stb = wr_go;
   assign wr_addr = aw_q;
   assign wr_data = w_q;
   assign rd_stb = s_arvalid && s_arready;
   assign rd_addr = s_araddr;
   // ----------------------------------------
   // write path
   // ----------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_q <= '0;
         w_q <= '0;
         s_bvalid <= 1'b0;
         s_bresp <= PBC_RESP_OKAY;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_held <= 1'b1;
            aw_q <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            w_held <= 1'b1;
            // only lane 0 carries register bits; a cleared strobe writes zero
            w_q <= s_wstrb[0] ? s_wdata[7:0] : 8'h00;
         end
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp <= wr_err ? PBC_RESP_SLVERR : PBC_RESP_OKAY;
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
         end
      end
   end
   // ----------------------------------------
   // read path
   // ----------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_rvalid <= 1'b0;
         s_rdata <= '0;
         s_rresp <= PBC_RESP_OKAY;
      end else if (rd_stb) begin
         s_rvalid <= 1'b1;
         s_rdata <= {24'h000000, rd_data};
         s_rresp <= rd_err ? PBC_RESP_SLVERR : PBC_RESP_OKAY;
      end else if (s_rvalid && s_rready) begin
         s_rvalid <= 1'b0;
      end
   end
endmodule // pbc_axil
`default_nettype wire

/* File: design/pbc_port.sv */
// four-pin bidirectional port with change detection and serial-unit hand-over
//
// How it works
// - change enable bits 7..4 switch change detection per pin
// - change enable resets to zero; low four bits ignore writes, read zero
// - direction zero drives the pin from the output latch
// - direction one releases the pin; reads give level; pull-up allowed
// - inputs pins 4 and 5 serve analog channels 10 and 11
// - input pin 4 feeds the SPI data input
// - in I2C pin 4 is SDA, pin 6 SCL, drive from serial unit
// - input pin 5 feeds USART asynchronous receive
// - synchronous USART data output overrides the latch on pin 5
// - SPI clock on pin 6 follows the direction bit
// - asynchronous USART transmit drives pin 7 despite input direction
// - synchronous mode: pin 7 is USART clock, out as master, in as slave
// - port, latch, direction, pull-up implement bits 7..4; rest read zero
// - enabled input pins compare with last-read value; mismatch sets flag
// - global change enable gates every per-pin change interrupt
// - port access ends mismatch; last-read latch survives soft resets
// - pull-up needs enable bit, global disable clear, input direction
`timescale 1ns/1ns
`default_nettype none
module pbc_port (
   input wire logic clk,
   input wire logic nrst,
   input wire logic por_nrst,
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   input wire logic [pbc_pkg::PBC_NPIN-1:0] pin_in,
   output logic [pbc_pkg::PBC_NPIN-1:0] pin_out,
   output logic [pbc_pkg::PBC_NPIN-1:0] pin_oe,
   output logic [pbc_pkg::PBC_NPIN-1:0] pin_pullup,
   output logic [pbc_pkg::PBC_NPIN-1:0] pin_analog,
   output logic [pbc_pkg::PBC_NPIN-1:0] pin_schmitt,
   input wire logic [pbc_pkg::PBC_NPIN-1:0] ser_ovr,
   input wire logic [pbc_pkg::PBC_NPIN-1:0] ser_out,
   input wire logic [pbc_pkg::PBC_NPIN-1:0] ser_oe,
   output logic [pbc_pkg::PBC_NPIN-1:0] ser_in,
   output logic spi_sdi,
   output logic usart_rx,
   output logic usart_ck_in,
   output logic change_irq_flag,
   output logic change_irq,
   output logic change_irq_priority
);
   import pbc_pkg::*;
   localparam int N = PBC_NPIN;
   // pin index within the 4-pin slice
   localparam int P4 = 0;
   localparam int P5 = 1;
   localparam int P6 = 2;
   localparam int P7 = 3;

   logic wr_stb;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic wr_err;
   logic rd_stb;
   logic [7:0] rd_addr;
   logic [7:0] rd_data;
   logic rd_err;
   logic [N-1:0] pin_sync;
   logic [N-1:0] pin_output_latch;
   logic [N-1:0] pin_direction;
   logic [N-1:0] pin_pullup_enable;
   logic [N-1:0] change_irq_enable;
   logic [3:0] analog_select_high;
   logic [7:0] irq_control_second;
   logic [4:0] serial_cfg;
   logic change_irq_global_enable;
   logic irq_control_global;
   logic [N-1:0] last_read;
   logic [N-1:0] digital_in;
   logic [N-1:0] mismatch;
   logic [N-1:0] drive_val;
   logic [N-1:0] drive_en;
   logic [N-1:0] an_sel;
   logic port_touch;
   logic flag_clear;
   logic spi_en;
   logic i2c_en;
   logic us_en;
   logic us_sync;
   logic us_master;

   // ----------------------------------------
   // bus front end and pin synchronisers
   // ----------------------------------------
   pbc_axil u_axil (
      .clk(clk),
      .nrst(nrst),
      .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid),
      .s_awready(s_awready),
      .s_wdata(s_wdata),
      .s_wstrb(s_wstrb),
      .s_wvalid(s_wvalid),
      .s_wready(s_wready),
      .s_bresp(s_bresp),
      .s_bvalid(s_bvalid),
      .s_bready(s_bready),
      .s_araddr(s_araddr),
      .s_arvalid(s_arvalid),
      .s_arready(s_arready),
      .s_rdata(s_rdata),
      .s_rresp(s_rresp),
      .s_rvalid(s_rvalid),
      .s_rready(s_rready),
      .wr_stb(wr_stb),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_err(wr_err),
      .rd_stb(rd_stb),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );

   pbc_sync #(.W(N)) u_sync (
      .clk(clk),
      .nrst(nrst),
      .d(pin_in),
      .q(pin_sync)
   );

   // ----------------------------------------
   // configuration decode
   // ----------------------------------------
   assign spi_en = serial_cfg[PBC_BIT_SPI_EN];
   assign i2c_en = serial_cfg[PBC_BIT_I2C_EN];
   assign us_en = serial_cfg[PBC_BIT_US_EN];
   assign us_sync = serial_cfg[PBC_BIT_US_SYNC];
   assign us_master = serial_cfg[PBC_BIT_US_MASTER];
   assign change_irq_global_enable = irq_control_global;
   assign change_irq_priority = irq_control_second[PBC_BIT_CHG_PRIO];
   // analog selection only takes effect on input pins 4 and 5
   assign an_sel = {2'b00, analog_select_high[PBC_BIT_ANALOG_CHANNEL_11], analog_select_high[PBC_BIT_ANALOG_CHANNEL_10]}
      & pin_direction;

   // ----------------------------------------
   // software registers, one word each
   // ----------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pin_direction <= PBC_RST_DIRECTION;
         change_irq_enable <= PBC_RST_CHG_EN;
         analog_select_high <= PBC_RST_ANALOG;
         irq_control_global <= 1'b0;
         irq_control_second <= PBC_RST_IRQ_CTRL2;
         serial_cfg <= '0;
         pin_output_latch <= PBC_RST_LATCH;
      end else if (wr_stb) begin
         case (wr_addr)
            // both the level and latch addresses write the output latch
            PBC_OFF_PIN_LEVEL: pin_output_latch <= wr_data[7:PBC_PIN_LO];
            PBC_OFF_LATCH: pin_output_latch <= wr_data[7:PBC_PIN_LO];
            PBC_OFF_DIRECTION: pin_direction <= wr_data[7:PBC_PIN_LO];
            PBC_OFF_CHG_EN: change_irq_enable <= wr_data[7:PBC_PIN_LO];
            PBC_OFF_ANALOG: analog_select_high <= wr_data[3:0];
            PBC_OFF_IRQ_CTRL: irq_control_global <= wr_data[PBC_BIT_CHG_GEN];
            PBC_OFF_IRQ_CTRL2: irq_control_second <= wr_data & 8'h85;
            PBC_OFF_SERIAL_CFG: serial_cfg <= wr_data[4:0];
            default: ;
         endcase
      end
   end

   // pull-up enables reset on power-on only
   always_ff @(posedge clk or negedge por_nrst) begin
      if (!por_nrst) begin
         pin_pullup_enable <= PBC_RST_PULLUP;
      end else if (wr_stb && wr_addr == PBC_OFF_PULLUP) begin
         pin_pullup_enable <= wr_data[7:PBC_PIN_LO];
      end
   end

   // decode misses answer with an error; the low two bits of each register address are zero
   assign wr_err = !(wr_addr <= PBC_OFF_SERIAL_CFG && wr_addr[1:0] == 2'b00);
   assign rd_err = !(rd_addr <= PBC_OFF_SERIAL_CFG && rd_addr[1:0] == 2'b00);

   // ----------------------------------------
   // digital input path
   // ----------------------------------------
   // analog pins read zero and never feed digital logic
   assign digital_in = pin_sync & ~an_sel;
   assign ser_in = digital_in;
   assign spi_sdi = digital_in[P4] & pin_direction[P4];
   assign usart_rx = digital_in[P5] & pin_direction[P5];
   assign usart_ck_in = digital_in[P7];

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   always_comb begin
      case (rd_addr)
         PBC_OFF_PIN_LEVEL: rd_data = {digital_in, 4'h0};
         PBC_OFF_LATCH: rd_data = {pin_output_latch, 4'h0};
         PBC_OFF_DIRECTION: rd_data = {pin_direction, 4'h0};
         PBC_OFF_PULLUP: rd_data = {pin_pullup_enable, 4'h0};
         PBC_OFF_CHG_EN: rd_data = {change_irq_enable, 4'h0};
         PBC_OFF_ANALOG: rd_data = {4'h0, analog_select_high};
         PBC_OFF_IRQ_CTRL: rd_data = {4'h0, irq_control_global, 2'b00, change_irq_flag};
         PBC_OFF_IRQ_CTRL2: rd_data = irq_control_second;
         PBC_OFF_SERIAL_CFG: rd_data = {3'b000, serial_cfg};
         default: rd_data = 8'h00;
      endcase
   end

   // ----------------------------------------
   // change detection
   // ----------------------------------------
   assign port_touch = (rd_stb && rd_addr == PBC_OFF_PIN_LEVEL)
      || (wr_stb && wr_addr == PBC_OFF_PIN_LEVEL);

   // the last-read copy lives on power-on reset only so soft resets keep it
   always_ff @(posedge clk or negedge por_nrst) begin
      if (!por_nrst) begin
         last_read <= '0;
      end else if (port_touch) begin
         last_read <= digital_in;
      end
   end

   // only enabled, digital input pins can mismatch
   assign mismatch = (digital_in ^ last_read) & change_irq_enable & pin_direction
      & ~an_sel;

   assign flag_clear = wr_stb && wr_addr == PBC_OFF_IRQ_CTRL && !wr_data[PBC_BIT_CHG_FLAG];

   // set beats clear: a standing mismatch keeps the flag raised through a clear write
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         change_irq_flag <= 1'b0;
      end else if (|mismatch) begin
         change_irq_flag <= 1'b1;
      end else if (flag_clear) begin
         change_irq_flag <= 1'b0;
      end
   end

   assign change_irq = change_irq_flag & change_irq_global_enable;

   // ----------------------------------------
   // pin drive selection
   // ----------------------------------------
   always_comb begin
      // plain port: latch value while direction is output
      drive_val = pin_output_latch;
      drive_en = ~pin_direction;
      // generic override from the serial units
      for (int i = 0; i < N; i++) begin
         if (ser_ovr[i]) begin
            drive_val[i] = ser_out[i];
            drive_en[i] = ser_oe[i];
         end
      end
      // I2C: serial unit owns drive on data and clock pins
      if (i2c_en) begin
         drive_val[P4] = ser_out[P4];
         drive_en[P4] = ser_oe[P4];
         drive_val[P6] = ser_out[P6];
         drive_en[P6] = ser_oe[P6];
      end else if (spi_en) begin
         drive_val[P6] = ser_out[P6];
         drive_en[P6] = ~pin_direction[P6];
      end
      if (us_en) begin
         if (us_sync) begin
            // synchronous data output beats the port latch
            drive_val[P5] = ser_out[P5];
            drive_en[P5] = ser_oe[P5];
            drive_val[P7] = ser_out[P7];
            drive_en[P7] = us_master;
         end else begin
            drive_val[P7] = ser_out[P7];
            drive_en[P7] = 1'b1;
         end
      end
      // analog pins are never driven
      drive_en = drive_en & ~an_sel;
   end

   // ----------------------------------------
   // registered pin outputs
   // ----------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pin_out <= '0;
         pin_oe <= '0;
         pin_pullup <= '0;
         pin_analog <= '0;
         pin_schmitt <= '0;
      end else begin
         pin_out <= drive_val;
         pin_oe <= drive_en;
         // pull-up only on undriven input pins with global disable clear
         pin_pullup <= pin_pullup_enable & pin_direction & ~drive_en
            & {N{!irq_control_second[PBC_BIT_PU_GDIS]}};
         pin_analog <= an_sel;
         // serial inputs use Schmitt buffers, plain port uses TTL
         pin_schmitt <= {us_en, spi_en | i2c_en, us_en, spi_en | i2c_en};
      end
   end
endmodule // pbc_port
`default_nettype wire

/* File: tb/pbc_port_asserts.sv */
// checker: bus handshake and change-flag properties of the pin port
`timescale 1ns/1ns
`default_nettype none
module pbc_port_asserts (
   input wire logic clk,
   input wire logic nrst,
   input wire logic s_awvalid,
   input wire logic s_awready,
   input wire logic s_wvalid,
   input wire logic s_wready,
   input wire logic s_bvalid,
   input wire logic s_arvalid,
   input wire logic s_arready,
   input wire logic s_rvalid,
   input wire logic s_rready,
   input wire logic [31:0] s_rdata,
   input wire logic [1:0] s_rresp,
   input wire logic [pbc_pkg::PBC_NPIN-1:0] pin_out,
   input wire logic [pbc_pkg::PBC_NPIN-1:0] pin_oe,
   input wire logic [pbc_pkg::PBC_NPIN-1:0] pin_analog,
   input wire logic [pbc_pkg::PBC_NPIN-1:0] ser_ovr,
   input wire logic change_irq_flag,
   input wire logic change_irq
);
   import pbc_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   irq_gate_a: assert property (change_irq |-> change_irq_flag)
      else $error("change irq without flag");
   read_answer_a: assert property (s_arvalid && s_arready |=> s_rvalid)
      else $error("read answer late");
   read_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
      else $error("read data dropped");
   write_answer_a: assert property (s_awvalid && s_awready && s_wvalid && s_wready
      |-> ##[1:3] s_bvalid) else $error("write answer late");
   err_zero_a: assert property (s_rvalid && s_rresp == PBC_RESP_SLVERR |-> s_rdata == 0)
      else $error("error read not zero");
   analog_quiet_a: assert property ((pin_analog & ~ser_ovr & ~$past(ser_ovr) & pin_oe)
      == 4'h0) else $error("analog pin driven");
   reset_quiet_a: assert property ($rose(nrst) |-> pin_oe == 4'h0 && !change_irq_flag)
      else $error("outputs not quiet after reset");
   // only a bus write may clear the flag; two idle cycles rule one out
   flag_hold_a: assert property (change_irq_flag && !s_awvalid && !s_wvalid &&
      !$past(s_awvalid) && !$past(s_wvalid) |=> change_irq_flag) else $error("flag lost");
   cover property (change_irq);
   cover property (s_rvalid && s_rresp == PBC_RESP_SLVERR);
   cover property (pin_oe != 4'h0);
endmodule // pbc_port_asserts
bind pbc_port pbc_port_asserts pbc_port_asserts_inst (.clk, .nrst, .s_awvalid, .s_awready,
   .s_wvalid, .s_wready, .s_bvalid, .s_arvalid, .s_arready, .s_rvalid, .s_rready, .s_rdata,
   .s_rresp, .pin_out, .pin_oe, .pin_analog, .ser_ovr, .change_irq_flag, .change_irq);
`default_nettype wire

/* File: tb/pbc_pins_model.sv */
// partner: external circuit on the four port pins
`timescale 1ns/1ns
`default_nettype none
module pbc_pins_model (
   input wire logic clk,
   input wire logic [3:0] pin_out,
   input wire logic [3:0] pin_oe,
   input wire logic [3:0] pin_pullup,
   input wire logic [3:0] ext_en,
   input wire logic [3:0] ext_val,
   output logic [3:0] pin_in
);
   logic [3:0] last;
   // a floating pin without pull-up shows the inverse of its last level, never a settled value
   always_ff @(posedge clk) begin
      last <= pin_in;
   end
   // device drive wins, then outside drive, then pull-up
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
      | (~pin_oe & ~ext_en & (pin_pullup | ~last));
endmodule // pbc_pins_model
`default_nettype wire

/* File: tb/tb.sv */
// testbench: registers, pin drive, serial hand-over and change flag
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
   import pbc_pkg::*;
   logic clk, nrst, por_nrst, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
   logic s_arvalid, s_arready, s_rvalid, s_rready, spi_sdi, usart_rx, usart_ck_in;
   logic change_irq_flag, change_irq, change_irq_priority;
   logic [7:0] s_awaddr, s_araddr, rd, v;
   logic [31:0] s_wdata, s_rdata;
   logic [3:0] s_wstrb, pin_in, pin_out, pin_oe, pin_pullup, pin_analog, pin_schmitt;
   logic [3:0] ser_ovr, ser_out, ser_oe, ser_in, ext_en, ext_val;
   logic [1:0] s_bresp, s_rresp, rsp;
   int fail_count, tests_run;
   logic [7:0] ra[4] = '{PBC_OFF_LATCH, PBC_OFF_DIRECTION, PBC_OFF_PULLUP, PBC_OFF_CHG_EN};
   logic [7:0] rv[4] = '{8'h00, 8'hF0, 8'hF0, 8'h00};
   logic [7:0] pc[3] = '{8'h00, 8'h80, 8'h00};
   logic [7:0] pd[3] = '{8'hF0, 8'hF0, 8'h30};
   logic [3:0] pe[3] = '{4'hF, 4'h0, 4'h3};
   logic [7:0] sc[3] = '{8'h02, 8'h04, 8'h1C};
   logic [3:0] sm[3] = '{4'h5, 4'h8, 4'hA};

   pbc_port pbc_port_inst (.clk, .nrst, .por_nrst, .s_awaddr, .s_awvalid, .s_awready,
      .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
      .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .pin_in, .pin_out,
      .pin_oe, .pin_pullup, .pin_analog, .pin_schmitt, .ser_ovr, .ser_out, .ser_oe, .ser_in,
      .spi_sdi, .usart_rx, .usart_ck_in, .change_irq_flag, .change_irq, .change_irq_priority);
   pbc_pins_model pbc_pins_model_inst (.clk, .pin_out, .pin_oe, .pin_pullup, .ext_en,
      .ext_val, .pin_in);

   // ----------------------------------------
   // clock, bus tasks and expectations
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // handshakes are judged at the falling edge, half a cycle before the rising edge, where nothing can race them
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic ah, wh, bh;
      @(posedge clk);
      s_awaddr <= a;
      s_wdata <= {24'h0, d};
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      bh = 1'b0;
      while (!bh) begin
         @(negedge clk);
         ah = s_awvalid & s_awready;
         wh = s_wvalid & s_wready;
         bh = s_bvalid;
         rsp = s_bresp;
         @(posedge clk);
         if (ah) s_awvalid <= 1'b0;
         if (wh) s_wvalid <= 1'b0;
      end
      s_bready <= 1'b0;
   endtask
   task automatic rdt(input logic [7:0] a);
      logic ah, rh;
      @(posedge clk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      rh = 1'b0;
      while (!rh) begin
         @(negedge clk);
         ah = s_arvalid & s_arready;
         rh = s_rvalid;
         rd = s_rdata[7:0];
         rsp = s_rresp;
         @(posedge clk);
         if (ah) s_arvalid <= 1'b0;
      end
      s_rready <= 1'b0;
   endtask
   // config to pin takes a register stage plus the two-flop input sync
   task automatic settle();
      repeat (4) @(posedge clk);
      @(negedge clk);
   endtask
   function automatic logic [7:0] impl(input logic [7:0] d);
      return {d[7:4], 4'h0};
   endfunction
   function automatic logic [7:0] lvl(input logic [3:0] x, input logic [1:0] an);
      return {x & ~{2'b00, an}, 4'h0};
   endfunction
   task automatic final_report();
      if (fail_count == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      final_report();
   end

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      {nrst, por_nrst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 7'h0;
      {s_awaddr, s_araddr, s_wdata, ser_ovr, ser_out, ser_oe, ext_val} = '0;
      s_wstrb = 4'hF;
      ext_en = 4'hF;
      void'($urandom(32'h77c5));
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      por_nrst <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         rdt(ra[i]);
         `CHK(rd, rv[i])
      end
      rdt(PBC_OFF_IRQ_CTRL2);
      `CHK(rd, PBC_RST_IRQ_CTRL2)
      `CHK(change_irq_priority, PBC_RST_IRQ_CTRL2[PBC_BIT_CHG_PRIO])
      // low nibble only first, then random words
      for (int k = 0; k < 3; k++) begin
         for (int i = 0; i < 4; i++) begin
            v = (k == 0) ? 8'h0F : 8'($urandom);
            wr(ra[i], v);
            rdt(ra[i]);
            `CHK(rd, impl(v))
         end
      end
      rdt(8'h24);
      `CHK({rsp, rd}, {PBC_RESP_SLVERR, 8'h00})
      rdt(8'h02);
      `CHK(rsp, PBC_RESP_SLVERR)
      wr(8'h24, 8'hFF);
      `CHK(rsp, PBC_RESP_SLVERR)
      v = 8'($urandom);
      wr(PBC_OFF_ANALOG, 8'h00);
      wr(PBC_OFF_LATCH, v);
      wr(PBC_OFF_DIRECTION, 8'h00);
      settle();
      `CHK({pin_oe, pin_out}, {4'hF, v[7:4]})
      wr(PBC_OFF_DIRECTION, 8'hF0);
      ext_val <= 4'($urandom);
      settle();
      rdt(PBC_OFF_PIN_LEVEL);
      `CHK(rd, lvl(ext_val, 2'b00))
      `CHK({usart_rx, spi_sdi}, ext_val[1:0])
      `CHK(ser_in, ext_val)
      `CHK(usart_ck_in, ext_val[3])
      wr(PBC_OFF_ANALOG, 8'h0C);
      settle();
      `CHK(pin_analog, 4'h3)
      rdt(PBC_OFF_PIN_LEVEL);
      `CHK(rd, lvl(ext_val, 2'b11))
      wr(PBC_OFF_ANALOG, 8'h00);
      wr(PBC_OFF_PULLUP, 8'hF0);
      for (int i = 0; i < 3; i++) begin
         wr(PBC_OFF_IRQ_CTRL2, pc[i]);
         wr(PBC_OFF_DIRECTION, pd[i]);
         settle();
         `CHK(pin_pullup, pe[i])
      end
      // change flag: snapshot, flip pin 6, clear while the mismatch persists
      wr(PBC_OFF_DIRECTION, 8'hF0);
      wr(PBC_OFF_CHG_EN, 8'hF0);
      rdt(PBC_OFF_PIN_LEVEL);
      wr(PBC_OFF_IRQ_CTRL, 8'h08);
      settle();
      `CHK(change_irq_flag, 1'b0)
      ext_val <= ext_val ^ 4'h4;
      settle();
      `CHK({change_irq, change_irq_flag}, 2'b11)
      wr(PBC_OFF_IRQ_CTRL, 8'h08);
      settle();
      `CHK(change_irq_flag, 1'b1)
      wr(PBC_OFF_IRQ_CTRL, 8'h00);
      settle();
      `CHK({change_irq, change_irq_flag}, 2'b01)
      rdt(PBC_OFF_PIN_LEVEL);
      wr(PBC_OFF_IRQ_CTRL, 8'h00);
      settle();
      `CHK(change_irq_flag, 1'b0)
      wr(PBC_OFF_CHG_EN, 8'hB0);
      ext_val <= ext_val ^ 4'h4;
      settle();
      `CHK(change_irq_flag, 1'b0)
      wr(PBC_OFF_LATCH, {~ext_val, 4'h0});
      wr(PBC_OFF_DIRECTION, 8'h70);
      settle();
      `CHK(change_irq_flag, 1'b0)
      // serial units take the pins: I2C, async and sync master USART
      wr(PBC_OFF_DIRECTION, 8'hF0);
      // no generic override, so only the mode decode can hand the pins over
      ser_ovr <= 4'h0;
      for (int i = 0; i < 3; i++) begin
         ser_out <= 4'($urandom);
         ser_oe <= (i == 1) ? 4'hF : (i == 2) ? (4'($urandom) | 4'h8) : 4'($urandom);
         wr(PBC_OFF_SERIAL_CFG, sc[i]);
         settle();
         `CHK(pin_out & ser_oe & sm[i], ser_out & ser_oe & sm[i])
         `CHK(pin_oe & sm[i], ser_oe & sm[i])
         `CHK(pin_schmitt, (i == 0) ? 4'h5 : 4'hA)
      end
      final_report();
   end
endmodule // tb
`default_nettype wire
